/* File: rtl/tsf_pkg.sv */
// Purpose: Shared constants and carriers for the thermal status flag block
// Assumes: 25 MHz core clock, 11-bit two's complement readings, 0.125 degree step
// Notes: Command codes select registers on the management bus read path
package tsf_pkg;

  // Command codes
  localparam logic [7:0] CMD_SUMMARY = 8'h02;
  localparam logic [7:0] CMD_DIODE_FAULT = 8'h07;
  localparam logic [7:0] CMD_ALARM_A = 8'h08;

  // Reset and idle values
  localparam logic [7:0] SUMMARY_RESET = 8'h00;
  localparam logic [7:0] REG_ZERO = 8'h00;

  // Summary field positions
  localparam int BUSY_BIT = 7;
  localparam int PENDING_BIT = 6;
  localparam int ALARM3_ANY_BIT = 3;
  localparam int ALARM2_ANY_BIT = 2;
  localparam int ALARM1_ANY_BIT = 1;
  localparam int DIODE_ANY_BIT = 0;

  // Channel numbering: local is 0, remotes 1 to 4
  localparam int NUM_CHAN = 5;
  localparam int NUM_REMOTE = 4;
  localparam logic [2:0] CHAN_LOCAL = 3'h0;
  localparam logic [2:0] CHAN_REMOTE1 = 3'h1;
  localparam logic [2:0] CHAN_REMOTE2 = 3'h2;

  // Temperature format
  localparam int TEMP_W = 11;
  localparam logic [TEMP_W-1:0] TEMP_SIGNED_FAULT = 11'h400;
  localparam logic [TEMP_W-1:0] TEMP_UNSIGNED_FAULT = 11'h000;

  // Power-up not-ready time
  localparam int CLK_FREQ_HZ = 25_000_000;
  localparam int NOT_READY_TIME_MS = 30;
  localparam int NOT_READY_CYCLES = (NOT_READY_TIME_MS * CLK_FREQ_HZ) / 1000;

  // One finished conversion, with the front end's diode condition sensing
  typedef struct packed {
    logic done;
    logic [2:0] chan;
    logic [TEMP_W-1:0] reading;
    logic dpAtGround;
    logic dpAtMinus;
    logic dpAtSupply;
    logic dpFloating;
  } tsf_conv_t;

  // Thresholds for the first alarm
  typedef struct packed {
    logic [NUM_CHAN-1:0][TEMP_W-1:0] critLimit;
    logic [1:0][TEMP_W-1:0] alarmALimit;
    logic [TEMP_W-1:0] hysteresis;
    logic [NUM_CHAN-1:0] mask;
  } tsf_limits_t;

endpackage

/* File: rtl/tsf_alarm_chan.sv */
// Purpose: One channel of threshold compare with shared hysteresis
// Assumes: Signed readings and limits, hysteresis non-negative
// Notes: Status only moves on an update strobe
`timescale 1ns/100ps
module tsf_alarm_chan #(
  parameter int TEMP_W = 11
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic update,
  input wire logic signed [TEMP_W-1:0] reading,
  input wire logic signed [TEMP_W-1:0] limit,
  input wire logic [TEMP_W-1:0] hysteresis,
  output logic status
);

  logic status_ff;
  logic signed [TEMP_W:0] lowMark;
  logic setCond;
  logic clearCond;

  // One extra bit so limit minus hysteresis cannot wrap; compare must stay signed
  assign lowMark = $signed({limit[TEMP_W-1], limit}) - $signed({1'b0, hysteresis});
  assign setCond = reading >= limit;
  assign clearCond = $signed({reading[TEMP_W-1], reading}) < lowMark;

  always_ff @(posedge clk) begin
    if (reset) begin
      status_ff <= 1'b0;
    end else if (update) begin
      if (setCond) begin
        status_ff <= 1'b1;
      end else if (clearCond) begin
        status_ff <= 1'b0;
      end
    end
  end

  assign status = status_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_set_at_limit:
    assert property (update && setCond |=> status_ff)
    else $error("alarm bit not set at or above limit");

  a_hold_in_band:
    assert property (update && status_ff && !clearCond |=> status_ff)
    else $error("alarm bit cleared inside hysteresis band");

  a_clear_below:
    assert property (update && !setCond && clearCond |=> !status_ff)
    else $error("alarm bit not cleared below low mark");

endmodule // tsf_alarm_chan

/* File: rtl/tsf_status.sv */
// Purpose: Read-only status registers of a multi-channel temperature monitor
// Assumes: Conversion engine and limit registers live elsewhere and feed this block
// Notes: Registers are read by command byte; answers come one cycle after the request
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////

// Behaviour
// - Summary bit 7 reads 1 while conversions run and 0 otherwise.
// - Summary bit 6 reads 1 during the roughly 30 ms power-up sequence, then 0.
// - Summary bits 5-4 and first alarm status bits 7-5 always read 0.
// - Summary bits 3-0 are the OR of alarm status registers 3, 2 and 1 and the diode fault register.
// - The summary register is read-only at command 0x02 and is 0x00 after reset.
// - The diode fault register is read-only at 0x07 with open and short bits per remote.
// - Remote n open sits at bit 2n-1 and short at bit 2n-2.
// - Short is D+ at ground or at D-, open is D+ at supply or floating.
// - A faulted channel's result reads 0 unsigned and -128.000 signed.
// - First alarm status reads at 0x08, bits 4-1 remotes 4-1, bit 0 local.
// - A first alarm bit sets when the reading reaches its channel's limit.
// - A set first alarm bit clears only below the limit minus shared hysteresis.
// - Remotes 1 and 2 use their own first alarm limits, the rest the critical limit.
// - The alarm output asserts when any unmasked first alarm status bit is set.
// - The alarm output deasserts once every unmasked first alarm status bit has cleared.
module tsf_status #(
  parameter int NOT_READY_CYCLES = tsf_pkg::NOT_READY_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic convBusy,
  input wire tsf_pkg::tsf_conv_t conv,
  input wire logic [tsf_pkg::NUM_CHAN-1:0] chanEnable,
  input wire tsf_pkg::tsf_limits_t limits,
  input wire logic [7:0] alarm2Status,
  input wire logic [7:0] alarm3Status,
  input wire logic rdReq,
  input wire logic [7:0] rdCmd,
  output logic rdAck,
  output logic [7:0] rdData,
  output logic resultValid,
  output logic [2:0] resultChan,
  output logic [tsf_pkg::TEMP_W-1:0] resultSigned,
  output logic [tsf_pkg::TEMP_W-1:0] resultUnsigned,
  output logic alarmOutAN
);

  localparam int TW = tsf_pkg::TEMP_W;
  localparam int NC = tsf_pkg::NUM_CHAN;

  ////////////////////////////////////////////////////////////////////////////////
  // Power-up sequencing

  typedef enum logic [2:0] {
    PU_IDLE = 3'b001,
    PU_WAIT = 3'b010,
    PU_READY = 3'b100
  } tsf_pu_state_t;

  tsf_pu_state_t puState_ff;
  tsf_pu_state_t nxt_puState;
  logic [31:0] puCount_ff;
  logic powerupPending;

  always_comb begin
    nxt_puState = puState_ff;
    case (puState_ff)
      PU_IDLE: begin
        nxt_puState = PU_WAIT;
      end
      PU_WAIT: begin
        if (puCount_ff >= 32'(NOT_READY_CYCLES - 1)) begin
          nxt_puState = PU_READY;
        end
      end
      PU_READY: begin
        nxt_puState = PU_READY;
      end
      default: begin
        nxt_puState = PU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      puState_ff <= PU_IDLE;
    end else begin
      puState_ff <= nxt_puState;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      puCount_ff <= 32'h0;
    end else if (puState_ff == PU_WAIT) begin
      puCount_ff <= puCount_ff + 32'h1;
    end
  end

  // Summary reads 0x00 in the first cycle out of reset, pending from the next
  assign powerupPending = (puState_ff == PU_WAIT);

  ////////////////////////////////////////////////////////////////////////////////
  // Diode fault register

  logic [7:0] diodeFault_ff;
  logic convRemote;
  logic convEnabled;
  logic faultShort;
  logic faultOpen;
  logic [1:0] remoteIdx;

  assign convEnabled = conv.done && chanEnable[conv.chan];
  assign convRemote = conv.chan != tsf_pkg::CHAN_LOCAL && conv.chan <= 3'(tsf_pkg::NUM_REMOTE);
  assign faultShort = conv.dpAtGround || conv.dpAtMinus;
  assign faultOpen = conv.dpAtSupply || conv.dpFloating;
  assign remoteIdx = 2'(conv.chan - 3'h1);

  always_ff @(posedge clk) begin
    if (reset) begin
      diodeFault_ff <= tsf_pkg::REG_ZERO;
    end else if (convEnabled && convRemote) begin
      diodeFault_ff[{remoteIdx, 1'b1}] <= faultOpen;
      diodeFault_ff[{remoteIdx, 1'b0}] <= faultShort;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reported result of the last conversion

  logic resultValid_ff;
  logic [2:0] resultChan_ff;
  logic [TW-1:0] resultSigned_ff;
  logic [TW-1:0] resultUnsigned_ff;
  logic convFault;

  assign convFault = convRemote && (faultShort || faultOpen);

  always_ff @(posedge clk) begin
    if (reset) begin
      resultValid_ff <= 1'b0;
      resultChan_ff <= tsf_pkg::CHAN_LOCAL;
      resultSigned_ff <= '0;
      resultUnsigned_ff <= '0;
    end else begin
      resultValid_ff <= convEnabled;
      if (convEnabled) begin
        resultChan_ff <= conv.chan;
        if (convFault) begin
          resultSigned_ff <= tsf_pkg::TEMP_SIGNED_FAULT;
          resultUnsigned_ff <= tsf_pkg::TEMP_UNSIGNED_FAULT;
        end else begin
          resultSigned_ff <= conv.reading;
          // Unsigned format cannot show below zero, so clamp there
          resultUnsigned_ff <= conv.reading[TW-1] ? '0 : conv.reading;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // First alarm status, one comparator per channel

  logic [NC-1:0] alarmAStat;
  logic [NC-1:0] chanUpdate;

  for (genvar ch = 0; ch < NC; ch++) begin : gChan
    logic [TW-1:0] chanLimit;
    // Remotes 1 and 2 carry a dedicated first alarm limit
    if (ch == 1 || ch == 2) begin : gOwn
      assign chanLimit = limits.alarmALimit[ch-1];
    end else begin : gCrit
      assign chanLimit = limits.critLimit[ch];
    end
    assign chanUpdate[ch] = convEnabled && conv.chan == 3'(ch) && !convFault;
    tsf_alarm_chan #(
      .TEMP_W(TW)
    ) uAlarm (
      .clk(clk),
      .reset(reset),
      .update(chanUpdate[ch]),
      .reading(conv.reading),
      .limit(chanLimit),
      .hysteresis(limits.hysteresis),
      .status(alarmAStat[ch])
    );
  end

  logic [7:0] alarmAReg;
  assign alarmAReg = {3'h0, alarmAStat};

  ////////////////////////////////////////////////////////////////////////////////
  // Alarm output pin

  logic alarmOutAN_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      alarmOutAN_ff <= 1'b1;
    end else begin
      // Low while any unmasked bit is set, high once clear
      alarmOutAN_ff <= ~|(alarmAStat & ~limits.mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Summary register

  logic [7:0] summary_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      summary_ff <= tsf_pkg::SUMMARY_RESET;
    end else begin
      summary_ff <= tsf_pkg::REG_ZERO;
      summary_ff[tsf_pkg::BUSY_BIT] <= convBusy;
      summary_ff[tsf_pkg::PENDING_BIT] <= powerupPending;
      summary_ff[tsf_pkg::ALARM3_ANY_BIT] <= |alarm3Status;
      summary_ff[tsf_pkg::ALARM2_ANY_BIT] <= |alarm2Status;
      summary_ff[tsf_pkg::ALARM1_ANY_BIT] <= |alarmAReg;
      summary_ff[tsf_pkg::DIODE_ANY_BIT] <= |diodeFault_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command byte read path; unmapped codes answer zero

  logic rdAck_ff;
  logic [7:0] rdData_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      rdAck_ff <= 1'b0;
      rdData_ff <= tsf_pkg::REG_ZERO;
    end else begin
      rdAck_ff <= rdReq;
      if (rdReq) begin
        case (rdCmd)
          tsf_pkg::CMD_SUMMARY: rdData_ff <= summary_ff;
          tsf_pkg::CMD_DIODE_FAULT: rdData_ff <= diodeFault_ff;
          tsf_pkg::CMD_ALARM_A: rdData_ff <= alarmAReg;
          default: rdData_ff <= tsf_pkg::REG_ZERO;
        endcase
      end
    end
  end

  assign rdAck = rdAck_ff;
  assign rdData = rdData_ff;
  assign resultValid = resultValid_ff;
  assign resultChan = resultChan_ff;
  assign resultSigned = resultSigned_ff;
  assign resultUnsigned = resultUnsigned_ff;
  assign alarmOutAN = alarmOutAN_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_busy_follows:
    assert property (!$past(reset) |-> summary_ff[tsf_pkg::BUSY_BIT] == $past(convBusy))
    else $error("busy bit does not follow conversion activity");

  a_pending_ends:
    assert property (puState_ff == PU_READY |=> !summary_ff[tsf_pkg::PENDING_BIT])
    else $error("not-ready bit still set after power-up");

  a_pending_starts:
    assert property ($rose(puState_ff == PU_WAIT) |=> summary_ff[tsf_pkg::PENDING_BIT])
    else $error("not-ready bit missing during power-up");

  a_reserved_zero:
    assert property (summary_ff[5:4] == 2'h0 && alarmAReg[7:5] == 3'h0)
    else $error("reserved bits read nonzero");

  a_any_flags:
    assert property (!$past(reset) |-> summary_ff[1:0] == {|$past(alarmAStat),
                                                           |$past(diodeFault_ff)})
    else $error("summary flag is not the OR of its register");

  a_summary_reset:
    assert property (@(posedge clk) $past(reset) |-> summary_ff == tsf_pkg::SUMMARY_RESET)
    else $error("summary register not zero after reset");

  a_read_fault:
    assert property (rdReq && rdCmd == tsf_pkg::CMD_DIODE_FAULT
                     |=> rdAck_ff && rdData_ff == $past(diodeFault_ff))
    else $error("diode fault read returned wrong data");

  a_open_bit:
    assert property (convEnabled && conv.chan == 3'h4 && conv.dpFloating
                     |=> diodeFault_ff[7])
    else $error("remote four open fault not at bit 7");

  a_fault_result:
    assert property (convEnabled && convFault
                     |=> resultSigned_ff == tsf_pkg::TEMP_SIGNED_FAULT
                         && resultUnsigned_ff == '0)
    else $error("faulted channel result not forced");

  a_read_alarm:
    assert property (rdReq && rdCmd == tsf_pkg::CMD_ALARM_A
                     |=> rdData_ff == {3'h0, $past(alarmAStat)})
    else $error("first alarm status read wrong");

  a_alarm_pin:
    assert property (!$past(reset) |-> alarmOutAN_ff == !(|($past(alarmAStat)
                                                            & ~$past(limits.mask))))
    else $error("alarm pin disagrees with unmasked status");

  a_disabled_hold:
    assert property (conv.done && !chanEnable[conv.chan] |=> $stable(alarmAStat)
                     && $stable(diodeFault_ff))
    else $error("disabled channel changed its status");

  a_short_bit:
    assert property (convEnabled && conv.chan == tsf_pkg::CHAN_REMOTE1 && conv.dpAtMinus
                     |=> diodeFault_ff[0])
    else $error("remote one short fault not at bit 0");

  a_local_no_fault:
    assert property (convEnabled && conv.chan == tsf_pkg::CHAN_LOCAL
                     |=> $stable(diodeFault_ff))
    else $error("local conversion touched diode fault bits");

  a_own_limit:
    assert property (chanUpdate[1] && $signed(conv.reading) >= $signed(limits.alarmALimit[0])
                     |=> alarmAStat[1])
    else $error("remote one ignored its own first alarm limit");

  a_pin_released:
    assert property (alarmAStat == '0 |=> alarmOutAN_ff)
    else $error("alarm pin held low with all status clear");

  c_powerup_done:
    cover property ($fell(summary_ff[tsf_pkg::PENDING_BIT]));

  c_alarm_fires:
    cover property ($fell(alarmOutAN_ff) ##[1:200] $rose(alarmOutAN_ff));

  c_fault_seen:
    cover property (convEnabled && convFault ##1 rdReq && rdCmd == tsf_pkg::CMD_DIODE_FAULT);

  c_local_update:
    cover property (chanUpdate[0]);

  c_alarm_masked:
    cover property (|alarmAStat && alarmOutAN_ff);

endmodule // tsf_status

/* File: test/tsf_host_model.sv */
// Purpose: Management bus host stand-in issuing register reads by command byte
// Assumes: One-cycle request pulse, taken on the rising edge
// Notes: Command lines show the inverse value once released
`timescale 1ns/100ps
module tsf_host_model (
  input wire logic clk,
  output logic rdReq,
  output logic [7:0] rdCmd
);
  initial begin
    rdReq = 1'b0;
    rdCmd = 8'hff;
  end

  task automatic read(input logic [7:0] cmd);
    @(negedge clk);
    rdReq = 1'b1;
    rdCmd = cmd;
    @(negedge clk);
    rdReq = 1'b0;
    // Stale command must not be mistaken for a held one
    rdCmd = ~cmd;
  endtask
endmodule // tsf_host_model

/* File: test/test_thermal_status_flags.sv */
// Purpose: Self-checking bench for the status flag block
// Assumes: Shortened power-up wait of 20 cycles
// Notes: Read answers are checked against a queue of expected bytes
`timescale 1ns/100ps
module test_thermal_status_flags;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic convBusy = 1'b0;
  tsf_pkg::tsf_conv_t conv = '0;
  logic [4:0] chanEnable = 5'h1f;
  tsf_pkg::tsf_limits_t limits;
  logic [7:0] alarm2Status = 8'h00;
  logic [7:0] alarm3Status = 8'h00;
  logic rdReq, rdAck, resultValid, alarmOutAN;
  logic [7:0] rdCmd, rdData, dfExp;
  logic [2:0] resultChan;
  logic [10:0] resultSigned, resultUnsigned, rdv;
  logic [4:0] alExp;
  logic [7:0] expQ[$];
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  int seedDummy;

  always #20 clk = ~clk;

  tsf_host_model host (.clk(clk), .rdReq(rdReq), .rdCmd(rdCmd));

  tsf_status #(.NOT_READY_CYCLES(20)) DUT (
    .clk(clk), .reset(reset), .convBusy(convBusy), .conv(conv), .chanEnable(chanEnable),
    .limits(limits), .alarm2Status(alarm2Status), .alarm3Status(alarm3Status),
    .rdReq(rdReq), .rdCmd(rdCmd), .rdAck(rdAck), .rdData(rdData),
    .resultValid(resultValid), .resultChan(resultChan), .resultSigned(resultSigned),
    .resultUnsigned(resultUnsigned), .alarmOutAN(alarmOutAN)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    expQ.push_back(exp);
    host.read(cmd);
  endtask

  task automatic convert(input logic [2:0] ch, input logic [10:0] r, input logic [3:0] cond);
    @(negedge clk);
    conv.done = 1'b1;
    conv.chan = ch;
    conv.reading = r;
    {conv.dpAtGround, conv.dpAtMinus, conv.dpAtSupply, conv.dpFloating} = cond;
    @(negedge clk);
    conv.done = 1'b0;
    check(11'(resultValid), 11'(chanEnable[ch]));
    if (chanEnable[ch]) begin
      check(11'(resultChan), 11'(ch));
    end
    if (chanEnable[ch] && cond == 4'h0) begin
      check(resultSigned, r);
      check(resultUnsigned, r[10] ? 11'h000 : r);
    end
    repeat (3) @(negedge clk);
    check(11'(resultValid), 11'h000);
  endtask

  function automatic logic [7:0] summ();
    return {convBusy, 3'h0, |alarm3Status, |alarm2Status, |alExp, |dfExp};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Answer watcher
  always @(posedge clk) begin
    if (rdAck === 1'b1) begin
      if (expQ.size() == 0)
        check(11'(rdData), 11'h7ff);
      else
        check(11'(rdData), 11'(expQ.pop_front()));
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seedDummy = $urandom(32'h0f34d228);
    limits = '0;
    limits.critLimit = {5{11'h3ff}};
    limits.critLimit[3] = 11'h0c8;
    limits.alarmALimit = {11'h0c8, 11'h0c8};
    limits.hysteresis = 11'h008;
    dfExp = 8'h00;
    alExp = 5'h00;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    check(11'(alarmOutAN), 11'h001);
    rd(8'h02, 8'h40);
    repeat (30) @(negedge clk);
    rd(8'h02, 8'h00);
    rd(8'h55, 8'h00);
    // Every fault condition on every remote, cleared after each
    for (int n = 1; n <= 4; n++) begin
      for (int k = 0; k < 4; k++) begin
        convert(3'(n), 11'h0d0, 4'b1000 >> k);
        dfExp = 8'h01 << ((k < 2) ? 2 * n - 2 : 2 * n - 1);
        check(resultSigned, 11'h400);
        check(resultUnsigned, 11'h000);
        rd(8'h07, dfExp);
        rd(8'h02, summ());
        rd(8'h08, 8'h00);
        convert(3'(n), 11'h000, 4'h0);
        dfExp = 8'h00;
      end
    end
    rd(8'h07, 8'h00);
    chanEnable[1] = 1'b0;
    convert(3'h1, 11'h0d0, 4'b1000);
    rd(8'h07, 8'h00);
    chanEnable[1] = 1'b1;
    // Remote 1 has its own limit; the local channel has no fault bits
    convert(3'h1, 11'h0d0, 4'h0);
    convert(3'h0, 11'h0d0, 4'b1000);
    rd(8'h08, 8'h02);
    rd(8'h07, 8'h00);
    convert(3'h1, 11'h000, 4'h0);
    // Remote 2 uses its own first-alarm limit, not the critical one
    convert(3'h2, 11'h0d0, 4'h0);
    alExp = 5'h04;
    rd(8'h08, 8'h04);
    rd(8'h02, summ());
    check(11'(alarmOutAN), 11'h000);
    limits.mask[2] = 1'b1;
    repeat (3) @(negedge clk);
    check(11'(alarmOutAN), 11'h001);
    limits.mask[2] = 1'b0;
    convert(3'h2, 11'h000, 4'h0);
    alExp = 5'h00;
    rd(8'h08, 8'h00);
    check(11'(alarmOutAN), 11'h001);
    // Random readings around remote 3 limit with hysteresis band
    for (int i = 0; i < 24; i++) begin
      rdv = 11'(184 + $urandom_range(0, 31));
      convert(3'h3, rdv, 4'h0);
      if (rdv >= 11'h0c8)
        alExp[3] = 1'b1;
      else if (rdv < 11'h0c0)
        alExp[3] = 1'b0;
      rd(8'h08, {3'h0, alExp});
      check(11'(alarmOutAN), 11'(~|alExp));
    end
    // A set bit must also clear for a reading below zero
    convert(3'h3, 11'h0d0, 4'h0);
    convert(3'h3, 11'h7f0, 4'h0);
    alExp[3] = 1'b0;
    rd(8'h08, {3'h0, alExp});
    convBusy = 1'b1;
    alarm2Status = 8'($urandom_range(1, 255));
    repeat (3) @(negedge clk);
    rd(8'h02, summ());
    convBusy = 1'b0;
    alarm2Status = 8'h00;
    alarm3Status = 8'($urandom_range(1, 255));
    repeat (3) @(negedge clk);
    rd(8'h02, summ());
    repeat (5) @(negedge clk);
    check(11'(expQ.size()), 11'h000);
    tally_and_finish;
  end
endmodule // test_thermal_status_flags
